// ==== srdp_pkg.sv ====
// Constants for the serial rate and data port
// Assumes the register port of the surrounding core addresses these offsets
package srdp_pkg;
  localparam logic [7:0] ADDR_CLOCK_DIVIDER = 8'h00_A2;
  localparam logic [7:0] ADDR_DATA_BUFFER   = 8'h00_A3;
  localparam logic [7:0] RESET_DIVIDER      = 8'h00_00;
  localparam logic [7:0] RESET_DATA         = 8'h00_00;
  localparam int unsigned CLOCK_PERIOD_NS   = 25;
  // Bit count per byte and slave-side timing figures in system clocks
  localparam logic [3:0] BITS_PER_BYTE      = 4'h0_8;
  localparam int unsigned SLAVE_OUT_MAX     = 4;
  localparam int unsigned LAST_EDGE_MIN     = 6;
  localparam int unsigned LAST_EDGE_MAX     = 8;
  localparam logic [2:0] LAST_EDGE_DELAY    = 3'h0_6;
  typedef enum logic [3:0] {
    SRDP_IDLE = 4'h0_1,
    SRDP_LEAD = 4'h0_2,
    SRDP_TRAIL = 4'h0_4,
    SRDP_DONE = 4'h0_8
  } srdp_state_t;
endpackage : srdp_pkg

// ==== srdp_core.sv ====
// Byte-wide serial port: clock divider, shared data register, master and slave shifting
// Assumes register accesses are single-cycle strobes synchronous to mclk_i
//
// What this block does and what it expects of the external devices
// [R1] Master serial clock equals system clock over two times the sum of divider and one.
// [R2] Writing the data register loads transmit buffer; in master mode starts transfer.
// [R3] Reading the data register returns the receive buffer.
// [R4] Clock polarity select inverts idle and active serial clock levels.
// [R5] External slave sets input data one clock plus 20 ns before shift edge.
// [R6] External master waits two clocks after select falls before first edge.
// [R7] External master holds select low two clocks after the last edge.
// [R8] Slave drives valid output within four clocks after select falls.
// [R9] Slave releases output within four clocks after select rises.
// [R10] External master holds input stable two clocks around each sample edge.
// [R11] Slave updates output within four clocks after each shift edge that comes once at least one bit of the byte is sampled.
// [R12] Slave with phase one changes output six to eight clocks after last edge.
// [R13] External master holds serial clock high and low five clocks each.
// [R14] Slave samples input data mid bit.
// [R15] Master samples input data one clock before the end of each bit, or on the clock that ends the bit when the divider is zero.
`timescale 1ns/10ps
module srdp_core (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       master_mode_i,
  input  wire logic       clock_polarity_select_i,
  input  wire logic       clock_phase_select_i,
  input  wire logic       sclk_i,
  output logic            sclk_o,
  output logic            sclk_oe_n_o,
  input  wire logic       slave_select_line_n_i,
  input  wire logic       sdi_i,
  output logic            sdo_o,
  output logic            sdo_oe_n_o,
  output logic            busy_o
);
  typedef struct packed {
    logic [7:0]            div;
    logic [7:0]            txbuf;
    logic [7:0]            rxbuf;
    logic [7:0]            shift;
    logic                  tx_pend;
    srdp_pkg::srdp_state_t st;
    logic [7:0]            cnt;
    logic [3:0]            bits;
    logic                  sclk;
    logic                  sdo;
    logic                  sdo_oe_n;
    logic                  sclk_oe_n;
    logic [7:0]            rdata;
    logic                  sck_prev;
    logic                  ss_prev;
    logic [2:0]            last_cnt;
    logic                  busy;
  } srdp_reg_t;

  srdp_reg_t q, d;
  logic      sck_norm;
  logic      lead_edge;
  logic      trail_edge;
  logic      shift_edge;
  logic      sample_edge;

  // Serial clock normalised to polarity zero, then edges seen by slave logic
  assign sck_norm    = sclk_i ^ clock_polarity_select_i; // R4
  assign lead_edge   = sck_norm & ~q.sck_prev;
  assign trail_edge  = ~sck_norm & q.sck_prev;
  assign shift_edge  = clock_phase_select_i ? lead_edge : trail_edge;
  assign sample_edge = clock_phase_select_i ? trail_edge : lead_edge;

  always_comb begin
    d = q;
    d.sck_prev = sck_norm;
    d.ss_prev  = slave_select_line_n_i;
    d.rdata    = 8'h00_00;
    if (reg_rd_i && reg_addr_i == srdp_pkg::ADDR_CLOCK_DIVIDER) begin
      d.rdata = q.div;
    end
    if (reg_rd_i && reg_addr_i == srdp_pkg::ADDR_DATA_BUFFER) begin
      d.rdata = q.rxbuf; // R3
    end
    if (reg_wr_i && reg_addr_i == srdp_pkg::ADDR_CLOCK_DIVIDER) begin
      d.div = reg_wdata_i;
    end
    if (reg_wr_i && reg_addr_i == srdp_pkg::ADDR_DATA_BUFFER) begin
      d.txbuf   = reg_wdata_i; // R2
      d.tx_pend = 1'b1;        // R2
    end
    if (master_mode_i) begin
      d.sdo_oe_n  = 1'b0;
      d.sclk_oe_n = 1'b0;
      case (q.st)
        srdp_pkg::SRDP_IDLE: begin
          d.sclk = clock_polarity_select_i; // R4
          d.busy = 1'b0;
          if (q.tx_pend) begin
            d.tx_pend = reg_wr_i && reg_addr_i == srdp_pkg::ADDR_DATA_BUFFER;
            d.shift   = q.txbuf;
            d.sdo     = q.txbuf[7];
            d.bits    = 4'h0_0;
            d.cnt     = q.div;
            d.busy    = 1'b1;
            d.st      = srdp_pkg::SRDP_LEAD; // R2
          end
        end
        srdp_pkg::SRDP_LEAD, srdp_pkg::SRDP_TRAIL: begin
          if (q.cnt == 8'h00_00) begin
            d.cnt  = q.div; // R1
            d.sclk = ~q.sclk;
            if (q.st == srdp_pkg::SRDP_LEAD) begin
              d.st = srdp_pkg::SRDP_TRAIL;
              if (clock_phase_select_i) begin
                d.sdo = q.shift[7];
              end
            end else begin
              d.bits = q.bits + 4'h0_1;
              d.st   = (q.bits == srdp_pkg::BITS_PER_BYTE - 4'h0_1) ?
                       srdp_pkg::SRDP_DONE : srdp_pkg::SRDP_LEAD;
              if (!clock_phase_select_i) begin
                // Sample already moved the next bit up unless the divider is zero
                d.sdo = (q.div == 8'h00_00) ? q.shift[6] : q.shift[7];
              end
            end
          end else begin
            d.cnt = q.cnt - 8'h00_01;
          end
          // Sample one system clock before the bit ends, or on the ending clock when the divider is zero
          if (q.st == srdp_pkg::SRDP_TRAIL && q.cnt == 8'h00_01 ||
              q.st == srdp_pkg::SRDP_TRAIL && q.div == 8'h00_00) begin
            d.shift = {q.shift[6:0], sdi_i}; // R15
          end
        end
        srdp_pkg::SRDP_DONE: begin
          d.rxbuf = q.shift;
          d.busy  = 1'b0;
          d.st    = srdp_pkg::SRDP_IDLE;
        end
        default: d.st = srdp_pkg::SRDP_IDLE;
      endcase
    end else begin
      d.st        = srdp_pkg::SRDP_IDLE;
      d.sclk_oe_n = 1'b1;
      d.sclk      = clock_polarity_select_i;
      d.sdo_oe_n  = slave_select_line_n_i; // R8 R9
      d.busy      = ~slave_select_line_n_i;
      if (slave_select_line_n_i) begin
        d.bits     = 4'h0_0;
        d.last_cnt = 3'h0_0;
      end else begin
        if (q.ss_prev) begin
          d.shift = q.txbuf;
          d.sdo   = q.txbuf[7]; // R8
        end
        if (sample_edge) begin
          // Input settles two clocks ahead, so the edge marks the bit middle
          d.shift = {q.shift[6:0], sdi_i}; // R14
          d.bits  = q.bits + 4'h0_1;
          if (q.bits == srdp_pkg::BITS_PER_BYTE - 4'h0_1) begin
            d.rxbuf = {q.shift[6:0], sdi_i};
            d.bits  = 4'h0_0;
            d.last_cnt = clock_phase_select_i ? 3'h0_1 : 3'h0_0;
          end
        end
        if (shift_edge && q.bits != 4'h0_0) begin
          d.sdo = q.shift[7]; // R11
        end
        if (q.last_cnt != 3'h0_0) begin
          d.last_cnt = q.last_cnt + 3'h0_1;
          if (q.last_cnt == srdp_pkg::LAST_EDGE_DELAY) begin
            d.sdo      = q.txbuf[7]; // R12
            d.shift    = q.txbuf;
            d.last_cnt = 3'h0_0;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q           <= '0;
      q.div       <= srdp_pkg::RESET_DIVIDER;
      q.txbuf     <= srdp_pkg::RESET_DATA;
      q.rxbuf     <= srdp_pkg::RESET_DATA;
      q.st        <= srdp_pkg::SRDP_IDLE;
      q.sdo_oe_n  <= 1'b1;
      q.sclk_oe_n <= 1'b1;
      q.ss_prev   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign sclk_o      = q.sclk;
  assign sclk_oe_n_o = q.sclk_oe_n;
  assign sdo_o       = q.sdo;
  assign sdo_oe_n_o  = q.sdo_oe_n;
  assign busy_o      = q.busy;

  sequence s_ss_fall;
    $fell(slave_select_line_n_i) && !master_mode_i;
  endsequence

  AST_SS_FALL_DRIVE: assert property (@(posedge mclk_i) disable iff (rst_i) // R8
    s_ss_fall ##1 (!master_mode_i && !slave_select_line_n_i) |-> !sdo_oe_n_o)
    else $error("slave output not driven after select fell");
  AST_SS_RISE_FLOAT: assert property (@(posedge mclk_i) disable iff (rst_i) // R9
    $rose(slave_select_line_n_i) && !master_mode_i |=> sdo_oe_n_o || master_mode_i)
    else $error("slave output not released after select rose");
  AST_RD_DATA: assert property (@(posedge mclk_i) disable iff (rst_i) // R3
    reg_rd_i && reg_addr_i == srdp_pkg::ADDR_DATA_BUFFER |=> reg_rdata_o == $past(q.rxbuf))
    else $error("data read did not return receive buffer");
  AST_WR_START: assert property (@(posedge mclk_i) disable iff (rst_i) // R2
    reg_wr_i && reg_addr_i == srdp_pkg::ADDR_DATA_BUFFER && master_mode_i
    && q.st == srdp_pkg::SRDP_IDLE && !q.tx_pend ##1 master_mode_i |=> busy_o)
    else $error("master write did not start transfer");
  AST_IDLE_POL: assert property (@(posedge mclk_i) disable iff (rst_i) // R4
    master_mode_i && q.st == srdp_pkg::SRDP_IDLE && $stable(clock_polarity_select_i)
    && !q.tx_pend |=> sclk_o == $past(clock_polarity_select_i))
    else $error("idle clock level wrong for polarity");
  AST_HALF_PERIOD: assert property (@(posedge mclk_i) disable iff (rst_i) // R1
    master_mode_i && $changed(sclk_o) && q.st == srdp_pkg::SRDP_TRAIL && $stable(q.div)
    |-> q.cnt == q.div)
    else $error("half period does not match divider");
  AST_SLAVE_SHIFT: assert property (@(posedge mclk_i) disable iff (rst_i) // R11
    !master_mode_i && !slave_select_line_n_i && shift_edge && q.bits != 4'h0_0
    |=> sdo_o == $past(q.shift[7]))
    else $error("slave output not updated after shift edge");
  AST_SLAVE_SAMPLE: assert property (@(posedge mclk_i) disable iff (rst_i) // R14
    !master_mode_i && !slave_select_line_n_i && sample_edge
    |=> q.shift[0] == $past(sdi_i))
    else $error("slave input not captured on sample edge");
endmodule : srdp_core

// ==== srdp_far_slave.sv ====
// Model of the external slave chip seen by the port in master mode
// Assumes the port drives sclk_o only while sclk_oe_n_o is low
// Assumes frame_i is high for the span of one byte, standing in for a select line
`timescale 1ns/10ps
module srdp_far_slave (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       sclk_o,
  input  wire logic       sclk_oe_n_o,
  input  wire logic       frame_i,
  input  wire logic [7:0] byte_i,
  output logic            sdi_o
);
  logic       prev_q;
  logic [3:0] cnt_q;
  // Clock level changes outside a frame, such as a polarity switch, are not counted
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= 4'h0;
      prev_q <= 1'b0;
    end else begin
      prev_q <= sclk_o;
      if (sclk_oe_n_o || !frame_i) cnt_q <= 4'h0;
      else if (sclk_o !== prev_q) cnt_q <= cnt_q + 4'h1;
    end
  end
  // Next bit one system clock after each trailing edge; released line inverts
  assign sdi_o = sclk_oe_n_o ? ~byte_i[0] : byte_i[3'h7 - cnt_q[3:1]];
endmodule : srdp_far_slave

// ==== spi_rate_and_data_port_test.sv ====
// Self-checking bench for the serial rate and data port
// Assumes the far slave model and the design core in the same folder
`timescale 1ns/10ps
module spi_rate_and_data_port_test;
  logic       mclk_i, rst_i, wr, rd, master, pol, pha, tsclk, ss_n, tsdi, psdi;
  logic       sclk_o, sclk_oe_n, sdo, sdo_oe_n, busy;
  logic [7:0] addr, wdata, rdata, pbyte, r;
  int         n_mismatch, comparisons;
  srdp_core dut (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .master_mode_i(master),
    .clock_polarity_select_i(pol), .clock_phase_select_i(pha), .sclk_i(tsclk),
    .sclk_o(sclk_o), .sclk_oe_n_o(sclk_oe_n), .slave_select_line_n_i(ss_n),
    .sdi_i(master ? psdi : tsdi), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .busy_o(busy));
  srdp_far_slave far (.mclk_i(mclk_i), .rst_i(rst_i), .sclk_o(sclk_o),
    .sclk_oe_n_o(sclk_oe_n), .frame_i(busy), .byte_i(pbyte), .sdi_o(psdi));
  always #12.5 mclk_i = ~mclk_i;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i); addr = a; wdata = d; wr = 1'b1;
    @(negedge mclk_i); wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_i); addr = a; rd = 1'b1;
    @(negedge mclk_i); rd = 1'b0; d = rdata;
  endtask : rd_reg
  task automatic summarize;
    if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic master_run(input logic p, input logic h, input logic [7:0] d);
    int n, gap; logic s; logic [7:0] q;
    pol = p; pha = h; n = 0; gap = 0; q = 8'h00_00; pbyte = p ? 8'h00_5A : 8'h00_A5;
    wr_reg(8'h00_A2, d); rd_reg(8'h00_A2, q); chk(q, d);
    @(negedge mclk_i); chk(sclk_o, p);
    wr_reg(8'h00_A3, 8'h00_3C);
    s = sclk_o;
    for (int k = 0; k < 5000 && n < 16; k++) begin
      @(negedge mclk_i); gap++;
      if (k == 1) chk(busy, 1'b1);
      if (sclk_o !== s) begin
        if (n > 0) chk(8'(gap - 1), d);
        if (n % 2 == 0) q = {q[6:0], sdo};
        n++; gap = 0; s = sclk_o;
      end
    end
    chk(8'(n), 8'h00_10);
    for (int k = 0; k < 600 && busy; k++) @(negedge mclk_i);
    chk(busy, 1'b0);
    chk(sclk_o, p);
    chk(q, 8'h00_3C);
    rd_reg(8'h00_A3, q); chk(q, pbyte);
  endtask : master_run
  task automatic slave_run(input logic h);
    logic [7:0] q, m;
    pha = h; m = 8'h00_C3;
    wr_reg(8'h00_A3, 8'h00_96);
    ss_n = 1'b0;
    repeat (4) @(negedge mclk_i);
    chk(sdo_oe_n, 1'b0);
    chk(sdo, 1'b1);
    for (int i = 7; i >= 0; i--) begin
      repeat (3) @(negedge mclk_i); if (!h) tsdi = m[i];
      repeat (3) @(negedge mclk_i); if (!h) q[i] = sdo; tsclk = ~tsclk;
      repeat (3) @(negedge mclk_i); if (h) tsdi = m[i];
      repeat (3) @(negedge mclk_i); if (h) q[i] = sdo; tsclk = ~tsclk;
    end
    repeat (5) @(negedge mclk_i);
    if (h) chk(sdo, 1'b0);
    repeat (3) @(negedge mclk_i);
    if (h) chk(sdo, 1'b1);
    @(negedge mclk_i); ss_n = 1'b1;
    repeat (4) @(negedge mclk_i);
    chk(sdo_oe_n, 1'b1);
    chk(q, 8'h00_96);
    rd_reg(8'h00_A3, q); chk(q, m);
  endtask : slave_run
  initial begin
    mclk_i = 0; rst_i = 1; wr = 0; rd = 0; addr = 0; wdata = 0; master = 0; pol = 0;
    pha = 0; tsclk = 0; ss_n = 1; tsdi = 0; pbyte = 0; n_mismatch = 0; comparisons = 0;
    repeat (12) @(negedge mclk_i); rst_i = 0;
    rd_reg(8'h00_A2, r); chk(r, 8'h00_00);
    rd_reg(8'h00_A3, r); chk(r, 8'h00_00);
    wr_reg(8'h00_10, 8'h00_FF); rd_reg(8'h00_10, r); chk(r, 8'h00_00);
    rd_reg(8'h00_A2, r); chk(r, 8'h00_00);
    master = 1;
    master_run(1'b0, 1'b0, 8'h00_02);
    master_run(1'b1, 1'b1, 8'h00_FF);
    master_run(1'b0, 1'b0, 8'h00_00);
    master = 0; pol = 0;
    slave_run(1'b0);
    slave_run(1'b1);
    summarize();
  end
  initial begin
    #1000000;
    n_mismatch++;
    summarize();
  end
endmodule : spi_rate_and_data_port_test
